/* testbench/sleep_and_power_reduction_tb.sv */
// Self-checking bench for the sleep and power control block
`timescale 1ns/1ns
module sleep_and_power_reduction_tb;
  // -------------------------------------------------------------
  // Signals and design
  // -------------------------------------------------------------
  localparam logic [15:0] TOUT = 16'h0014;
  localparam logic [7:0]  SC   = slp_pkg::SLEEP_CONTROL_IDX;
  localparam logic [7:0]  PR0  = slp_pkg::POWER_REDUCE_0_IDX;
  localparam logic [7:0]  PR1  = slp_pkg::POWER_REDUCE_1_IDX;
  logic                 clock = 1'b0;
  logic                 resetn = 1'b0;
  logic                 hsel = 1'b0;
  logic                 hwrite = 1'b0;
  logic [31:0]          haddr = '0;
  logic [31:0]          hwdata = '0;
  logic [1:0]           htrans = '0;
  logic                 sleepInstr = 1'b0;
  logic                 wakeIrq = 1'b0;
  logic                 resetSources = 1'b0;
  logic                 bof = 1'b0;
  logic                 dbg = 1'b0;
  logic                 wdg = 1'b0;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic                 portReset;
  logic                 coreReset;
  logic                 cpuResume;
  logic                 sleeping;
  slp_pkg::slp_clken_s  clockEnables;
  slp_pkg::slp_analog_s analogEnables;
  int                   num_errors = 0;
  int                   checks_done = 0;

  always #20 clock = ~clock;

  slp_power_ctrl #(.CNT_W(16)) dut (
    .clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleepInstr,
    .wakeIrq, .resetSources, .brownoutLevelFuses(bof),
    .debugEnableFuse(dbg), .startupTimeout(TOUT), .watchdogEnabled(wdg),
    .clockEnables, .analogEnables, .portReset, .coreReset, .cpuResume,
    .sleeping);

  // -------------------------------------------------------------
  // Tasks and expectations
  // -------------------------------------------------------------
  task automatic complete_run;
    $display("Counts: %0d checks, %0d errors", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic hang(input string what);
    num_errors++;
    $display("FAIL %s expected done seen timeout", what);
    complete_run();
  endtask

  // Holds each phase until hready is sampled high
  task automatic bus(input logic [7:0] i, input logic w,
                     input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 99);
    r = hrdata;
    if (n >= 99) hang("bus");
  endtask

  task automatic wr(input logic [7:0] i, d);
    logic [31:0] r;
    bus(i, 1'b1, d, r);
  endtask

  task automatic rdc(input string what, input logic [7:0] i, e);
    logic [31:0] r;
    bus(i, 1'b0, 8'h00, r);
    check(what, {24'h0, e}, r);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_core;
    int n;
    n = 0;
    while (coreReset !== 1'b0 && n < 200) begin @(posedge clock); n++; end
    if (n >= 200) hang("coreReset");
    check("stretch", 1, n >= TOUT && n <= TOUT + 8);
  endtask

  // Minimum cycles from wake request to resume, per mode
  task automatic sleep_wake(input logic [2:0] code, input logic se);
    int n;
    int lim;
    lim = code == 3'b000 ? 4 : (code[2:1] == 2'b11 ? 10 : TOUT + 4);
    wr(SC, {4'h0, code, se});
    sleepInstr <= 1'b1;
    @(posedge clock);
    sleepInstr <= 1'b0;
    repeat (4) @(posedge clock);
    check("sleeping", se && valid(code), sleeping);
    if (sleeping === 1'b1) begin
      check("cpu flash io", {2'b00, !code}, clockEnables[8:6]);
      check("inputBuf", !code, analogEnables.inputBuf);
      check("comparator", !code, analogEnables.comparator);
      check("mainOsc", !code || &code[2:1] || dbg, clockEnables.mainOsc);
      n = 0;
      wakeIrq <= 1'b1;
      while (cpuResume !== 1'b1 && n < 300) begin @(posedge clock); n++; end
      wakeIrq <= 1'b0;
      if (n >= 300) hang("wake");
      check("wake delay", 1, n >= lim);
    end
  endtask

  function automatic logic valid(input logic [2:0] c);
    return c inside {3'b000, 3'b010, 3'b011, 3'b110, 3'b111};
  endfunction

  function automatic logic [4:0] gates(input logic [7:0] p0, p1);
    return ~{p0[5], p0[3], p0[2], p1[7], p1[0]};
  endfunction

  initial begin
    repeat (100000) @(posedge clock);
    hang("run");
  end

  initial begin
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] d;
    void'($urandom(32'h5899d94c));
    repeat (20) @(posedge clock);
    check("portReset", 1, portReset);
    check("coreReset", 1, coreReset);
    resetn <= 1'b1;
    wait_core();
    rdc("sleep_control", SC, 8'h00);
    rdc("power_reduce_1", PR1, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      p0 = k == 0 ? 8'hff : 8'($urandom);
      p1 = k == 0 ? 8'hff : 8'($urandom);
      d = k == 0 ? 8'hf0 : {4'($urandom), 3'b001, 1'b0};
      wr(PR0, p0);
      wr(PR1, p1);
      wr(SC, d);
      rdc("power_reduce_0", PR0, p0 & slp_pkg::POWER_REDUCE_0_MASK);
      rdc("power_reduce_1", PR1, p1 & slp_pkg::POWER_REDUCE_1_MASK);
      rdc("sleep_control", SC, d & slp_pkg::SLEEP_CONTROL_MASK);
      check("gates", gates(p0, p1), clockEnables[4:0]);
    end
    wr(8'h40, 8'hff);
    rdc("unmapped", 8'h40, 8'h00);
    wr(PR0, 8'h00);
    wr(PR1, 8'h00);
    $display("register test done");
    for (int c = 0; c < 16; c++) begin
      bof <= 1'($urandom);
      dbg <= 1'($urandom);
      wdg <= 1'($urandom);
      sleep_wake(3'(c >> 1), c[0]);
      wr(SC, 8'h00);
    end
    $display("sleep mode test done");
    bof <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(slp_pkg::CONFIG_IDX, 8'(c));
      wr(SC, 8'h05);
      sleepInstr <= 1'b1;
      @(posedge clock);
      sleepInstr <= 1'b0;
      repeat (4) @(posedge clock);
      check("bandgap", c == 2, analogEnables.bandgap);
      check("comparator", 0, analogEnables.comparator);
      wakeIrq <= 1'b1;
      repeat (TOUT + 12) @(posedge clock);
      wakeIrq <= 1'b0;
      check("awake", 0, sleeping);
      sleep_wake(3'b010, c[0]);
    end
    $display("reference test done");
    wr(PR0, 8'h24);
    resetSources <= 1'b1;
    repeat (3) @(posedge clock);
    check("portReset", 1, portReset);
    check("coreReset", 1, coreReset);
    resetSources <= 1'b0;
    wait_core();
    rdc("power_reduce_0", PR0, 8'h00);
    $display("source reset test done");
    complete_run();
  end
endmodule

/* testbench/slp_power_ctrl_chk.sv */
// Port-level assertion checker for the sleep and power control block
`timescale 1ns/1ns
module slp_power_ctrl_chk #(
  parameter int CNT_W = 16
) (
  // Clock, reset and inputs
  input wire logic                 clock,
  input wire logic                 resetn,
  input wire logic                 resetSources,
  input wire logic                 sleepInstr,
  input wire logic                 brownoutLevelFuses,
  input wire logic                 debugEnableFuse,
  input wire logic                 watchdogEnabled,
  input wire logic [CNT_W-1:0]     startupTimeout,
  // Outputs watched
  input wire slp_pkg::slp_clken_s  clockEnables,
  input wire slp_pkg::slp_analog_s analogEnables,
  input wire logic                 portReset,
  input wire logic                 coreReset,
  input wire logic                 cpuResume,
  input wire logic                 sleeping
);
  // -------------------------------------------------------------
  // Reset stretch counter
  // -------------------------------------------------------------
  logic [CNT_W:0] relCnt;

  always_ff @(posedge clock) begin
    if (!resetn || resetSources) begin
      relCnt <= '0;
    end else if (coreReset) begin
      relCnt <= relCnt + 1'b1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence deepSleep;
    (sleeping && !clockEnables.io)[*2];
  endsequence

  a_port_reset: assert property (resetSources |=> portReset)
    else $error("port reset missed a reset source");
  a_core_held: assert property (resetSources |-> ##2 coreReset)
    else $error("core reset not held by source");
  a_stretch_min: assert property ($fell(coreReset) |->
    relCnt >= startupTimeout) else $error("core reset released early");
  a_stretch_max: assert property (coreReset && !resetSources |->
    relCnt <= startupTimeout + 8) else $error("core reset held too long");
  a_brownout_kept: assert property (
    (brownoutLevelFuses && !coreReset)[*2] |->
    analogEnables.brownout && analogEnables.bandgap)
    else $error("brownout or reference dropped");
  a_watchdog_kept: assert property (
    (watchdogEnabled && !coreReset)[*2] |-> analogEnables.watchdog)
    else $error("watchdog dropped");
  a_debug_osc: assert property (
    (debugEnableFuse && sleeping)[*2] |-> clockEnables.mainOsc)
    else $error("main clock stopped under debug");
  a_sleep_cpu: assert property (sleeping[*2] |->
    !clockEnables.cpu && !clockEnables.flash)
    else $error("cpu clock runs in sleep");
  a_deep_analog: assert property (deepSleep |->
    !analogEnables.comparator && !analogEnables.inputBuf)
    else $error("comparator or inputs on in deep sleep");
  a_resume_pulse: assert property (cpuResume |=> !cpuResume)
    else $error("resume longer than one cycle");
  a_sleep_cause: assert property ($rose(sleeping) |->
    $past(sleepInstr, 1) || $past(sleepInstr, 2) || $past(sleepInstr, 3))
    else $error("sleep without instruction");
endmodule

bind slp_power_ctrl slp_power_ctrl_chk #(.CNT_W(CNT_W)) u_chk (
  .clock, .resetn, .resetSources, .sleepInstr, .brownoutLevelFuses,
  .debugEnableFuse, .watchdogEnabled, .startupTimeout, .clockEnables,
  .analogEnables, .portReset, .coreReset, .cpuResume, .sleeping);

/* verilog/slp_delay_counter.sv */
// Reset stretching delay counter
`timescale 1ns/1ns
module slp_delay_counter #(
  parameter int CNT_W = 16
) (
  // Clock and source reset
  input  wire logic             clock,
  input  wire logic             srcActive,
  // Time-out length
  input  wire logic [CNT_W-1:0] timeout,
  // Stretched reset
  output logic                  resetHeld
);

  logic [CNT_W-1:0] count_r;

  // Counter restarts whenever any source is active
  always_ff @(posedge clock) begin
    if (srcActive) begin
      count_r <= '0;
    end else if (count_r != timeout) begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    resetHeld <= srcActive || (count_r != timeout);
  end

endmodule

/* verilog/slp_pkg.sv */
// Package of constants and types for the sleep and power reduction block
package slp_pkg;

  // ---------------------------------------------------------------
  // Register map (word indices; the byte address is four times these)
  // ---------------------------------------------------------------
  localparam logic [7:0] SLEEP_CONTROL_IDX  = 8'h33;
  localparam logic [7:0] POWER_REDUCE_0_IDX = 8'h64;
  localparam logic [7:0] POWER_REDUCE_1_IDX = 8'h65;
  localparam logic [7:0] STATUS_IDX         = 8'h66;
  localparam logic [7:0] CONFIG_IDX         = 8'h67;
  localparam int         ADDR_W             = 10;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SLEEP_CONTROL_MASK  = 8'h0f;
  localparam logic [7:0] POWER_REDUCE_0_MASK = 8'h2c;
  localparam logic [7:0] POWER_REDUCE_1_MASK = 8'h81;
  localparam logic [7:0] CONFIG_MASK         = 8'h03;
  localparam logic [7:0] REG_RESET           = 8'h00;
  localparam int         SE_BIT              = 0;
  localparam int         SEL_LSB             = 1;
  localparam int         TIMER0_BIT          = 5;
  localparam int         TIMER1_BIT          = 3;
  localparam int         SPI_BIT             = 2;
  localparam int         USB_BIT             = 7;
  localparam int         SERIAL_BIT          = 0;
  localparam int         CMP_OFF_BIT         = 0;
  localparam int         CMP_BANDGAP_BIT     = 1;

  // ---------------------------------------------------------------
  // Sleep select codes and machine states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_IDLE     = 3'b000,
    SEL_RES1     = 3'b001,
    SEL_PDOWN    = 3'b010,
    SEL_PSAVE    = 3'b011,
    SEL_RES4     = 3'b100,
    SEL_RES5     = 3'b101,
    SEL_STANDBY  = 3'b110,
    SEL_XSTANDBY = 3'b111
  } slp_mode_e;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_RUN    = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_WAKE   = 3'b011,
    ST_HALT   = 3'b100
  } slp_state_e;

  // Timing
  localparam int         WAKE_HALT_CYCLES = 4;
  localparam int         STANDBY_WAKE     = 6;
  localparam int         CNT_W            = 16;

  // Clock gate bundle towards the rest of the chip
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic mainOsc;
    logic timer0;
    logic timer1;
    logic spi;
    logic usb;
    logic serial;
  } slp_clken_s;

  // Analog enables
  typedef struct packed {
    logic bandgap;
    logic comparator;
    logic brownout;
    logic watchdog;
    logic inputBuf;
  } slp_analog_s;

endpackage

/* verilog/slp_power_ctrl.sv */
// Sleep mode control, clock gating and reset stretch for the core
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module slp_power_ctrl #(
  parameter int CNT_W = slp_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                resetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Core events
  input  wire logic                sleepInstr,
  input  wire logic                wakeIrq,
  input  wire logic                resetSources,
  // Fuses
  input  wire logic                brownoutLevelFuses,
  input  wire logic                debugEnableFuse,
  input  wire logic [CNT_W-1:0]    startupTimeout,
  input  wire logic                watchdogEnabled,
  // Outputs to the chip
  output slp_pkg::slp_clken_s      clockEnables,
  output slp_pkg::slp_analog_s     analogEnables,
  output logic                     portReset,
  output logic                     coreReset,
  output logic                     cpuResume,
  output logic                     sleeping
);

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  logic [7:0]   sleepControl_r;
  logic [7:0]   powerReduce0_r;
  logic [7:0]   powerReduce1_r;
  logic [7:0]   config_r;
  logic         wrPend_r;
  logic [7:0]   wrIdx_r;
  logic         resetHeld;
  logic         sysResetn;
  logic         wrHit;
  logic [7:0]   rdIdx;
  logic [7:0]   rdByte;
  slp_pkg::slp_state_e state_r;
  slp_pkg::slp_mode_e  mode_r;
  logic [CNT_W-1:0]    wait_r;
  logic                refWanted;

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [7:0] addrIdx(input logic [31:0] a);
    addrIdx = a[slp_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic modeValid(input logic [2:0] m);
    modeValid = (m == slp_pkg::SEL_IDLE) || (m == slp_pkg::SEL_PDOWN) ||
                (m == slp_pkg::SEL_PSAVE) || (m == slp_pkg::SEL_STANDBY) ||
                (m == slp_pkg::SEL_XSTANDBY);
  endfunction

  // Both standby codes keep the oscillator up, so they wake quickly
  function automatic logic isStandby(input slp_pkg::slp_mode_e m);
    isStandby = (m == slp_pkg::SEL_STANDBY) || (m == slp_pkg::SEL_XSTANDBY);
  endfunction

  // -------------------------------------------------------------
  // Reset stretching
  // -------------------------------------------------------------
  // The instance runs off the raw sources; the core reset is its output registered once more
  slp_delay_counter #(
    .CNT_W     (CNT_W)
  ) u_delay (
    .clock     (clock),
    .srcActive (resetSources || !resetn),
    .timeout   (startupTimeout),
    .resetHeld (resetHeld)
  );

  assign sysResetn = !resetHeld;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= resetHeld;
    end
  end

  // Registered like every output, so this copy trails the source by one
  // edge and needs a running clock. The pad cell is expected to OR in
  // the raw source, which is what resets the pins with no clock at all;
  // this flop keeps them reset for as long as the source is seen.
  always_ff @(posedge clock) begin
    portReset <= resetSources || !resetn;
  end

  // -------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // -------------------------------------------------------------
  // Write data trail their address phase by one cycle, so the index
  // is held for the edge that lands them in the register
  assign wrHit = hsel && hready && htrans[1] && hwrite;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPend_r <= 1'b0;
      wrIdx_r  <= slp_pkg::REG_RESET;
    end else begin
      wrPend_r <= wrHit;
      wrIdx_r  <= addrIdx(haddr);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign rdIdx = addrIdx(haddr);

  always_comb begin
    unique case (rdIdx)
      slp_pkg::SLEEP_CONTROL_IDX:
        rdByte = sleepControl_r & slp_pkg::SLEEP_CONTROL_MASK;
      slp_pkg::POWER_REDUCE_0_IDX:
        rdByte = powerReduce0_r & slp_pkg::POWER_REDUCE_0_MASK;
      slp_pkg::POWER_REDUCE_1_IDX:
        rdByte = powerReduce1_r & slp_pkg::POWER_REDUCE_1_MASK;
      slp_pkg::STATUS_IDX:
        rdByte = {5'h00, state_r};
      slp_pkg::CONFIG_IDX:
        rdByte = config_r & slp_pkg::CONFIG_MASK;
      default:
        rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= {24'h000000, rdByte};
    end
  end

  // -------------------------------------------------------------
  // Software registers
  // -------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!sysResetn) begin
      sleepControl_r <= slp_pkg::REG_RESET;
    end else if (wrPend_r && wrIdx_r == slp_pkg::SLEEP_CONTROL_IDX) begin
      sleepControl_r <= hwdata[7:0] & slp_pkg::SLEEP_CONTROL_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!sysResetn) begin
      powerReduce0_r <= slp_pkg::REG_RESET;
    end else if (wrPend_r && wrIdx_r == slp_pkg::POWER_REDUCE_0_IDX) begin
      powerReduce0_r <= hwdata[7:0] & slp_pkg::POWER_REDUCE_0_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!sysResetn) begin
      powerReduce1_r <= slp_pkg::REG_RESET;
    end else if (wrPend_r && wrIdx_r == slp_pkg::POWER_REDUCE_1_IDX) begin
      powerReduce1_r <= hwdata[7:0] & slp_pkg::POWER_REDUCE_1_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!sysResetn) begin
      config_r <= slp_pkg::REG_RESET;
    end else if (wrPend_r && wrIdx_r == slp_pkg::CONFIG_IDX) begin
      config_r <= hwdata[7:0] & slp_pkg::CONFIG_MASK;
    end
  end

  // -------------------------------------------------------------
  // Sleep state machine
  // -------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!sysResetn) begin
      state_r <= slp_pkg::ST_RESET;
      mode_r  <= slp_pkg::SEL_IDLE;
      wait_r  <= '0;
    end else begin
      unique case (state_r)
        slp_pkg::ST_RESET: begin
          state_r <= slp_pkg::ST_RUN;
        end
        slp_pkg::ST_RUN: begin
          // Reserved codes and a clear enable bit leave the core running
          if (sleepInstr && sleepControl_r[slp_pkg::SE_BIT] &&
              modeValid(sleepControl_r[slp_pkg::SEL_LSB +: 3])) begin
            state_r <= slp_pkg::ST_SLEEP;
            mode_r  <= slp_pkg::slp_mode_e'(
                         sleepControl_r[slp_pkg::SEL_LSB +: 3]);
          end
        end
        slp_pkg::ST_SLEEP: begin
          if (wakeIrq) begin
            state_r <= slp_pkg::ST_WAKE;
            // Deep modes restart the oscillator; standby keeps it running
            if (mode_r == slp_pkg::SEL_IDLE) begin
              wait_r <= '0;
            end else if (isStandby(mode_r)) begin
              wait_r <= CNT_W'(slp_pkg::STANDBY_WAKE);
            end else begin
              wait_r <= startupTimeout;
            end
          end
        end
        slp_pkg::ST_WAKE: begin
          if (wait_r == '0) begin
            state_r <= slp_pkg::ST_HALT;
            wait_r  <= CNT_W'(slp_pkg::WAKE_HALT_CYCLES - 1);
          end else begin
            wait_r <= wait_r - CNT_W'(1);
          end
        end
        slp_pkg::ST_HALT: begin
          if (wait_r == '0) begin
            state_r <= slp_pkg::ST_RUN;
          end else begin
            wait_r <= wait_r - CNT_W'(1);
          end
        end
        default: begin
          state_r <= slp_pkg::ST_RESET;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Clock and analog enables
  // -------------------------------------------------------------
  logic asleep;
  logic ioStopped;
  logic cmpOn;
  assign asleep    = (state_r == slp_pkg::ST_SLEEP) ||
                     (state_r == slp_pkg::ST_WAKE);
  assign ioStopped = asleep && (mode_r != slp_pkg::SEL_IDLE);
  // Any sleep but idle drops the comparator, whatever its input
  assign cmpOn     = !config_r[slp_pkg::CMP_OFF_BIT] && !ioStopped;
  // A comparator left on the bandgap holds the reference up in every
  // sleep mode; switching the comparator off or clearing its bandgap bit releases it
  assign refWanted = !config_r[slp_pkg::CMP_OFF_BIT] &&
                     config_r[slp_pkg::CMP_BANDGAP_BIT];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      clockEnables <= '0;
    end else begin
      clockEnables.cpu     <= !asleep && state_r != slp_pkg::ST_HALT;
      clockEnables.flash   <= !asleep;
      clockEnables.io      <= !ioStopped;
      clockEnables.mainOsc <= !ioStopped || debugEnableFuse ||
                              isStandby(mode_r);
      clockEnables.timer0  <= !ioStopped &&
                              !powerReduce0_r[slp_pkg::TIMER0_BIT];
      clockEnables.timer1  <= !ioStopped &&
                              !powerReduce0_r[slp_pkg::TIMER1_BIT];
      clockEnables.spi     <= !ioStopped &&
                              !powerReduce0_r[slp_pkg::SPI_BIT];
      clockEnables.usb     <= !ioStopped &&
                              !powerReduce1_r[slp_pkg::USB_BIT];
      clockEnables.serial  <= !ioStopped &&
                              !powerReduce1_r[slp_pkg::SERIAL_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      analogEnables <= '0;
    end else begin
      analogEnables.comparator <= cmpOn;
      analogEnables.brownout   <= brownoutLevelFuses;
      analogEnables.bandgap    <= brownoutLevelFuses || refWanted;
      analogEnables.watchdog   <= watchdogEnabled;
      analogEnables.inputBuf   <= !ioStopped;
    end
  end

  // One-cycle pulse in the cycle after the last halt cycle of a wake
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpuResume <= 1'b0;
    end else begin
      cpuResume <= (state_r == slp_pkg::ST_HALT) && (wait_r == '0);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sleeping <= 1'b0;
    end else begin
      sleeping <= asleep;
    end
  end

endmodule
